// ---- uddp_pkg.sv ----
// Register map, field positions and types of the UART data and divisor port
package uddp_pkg;
   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] ADDR_DATA  = 8'h00;
   localparam logic [7:0] ADDR_DLH   = 8'h04;
   localparam logic [7:0] ADDR_FCR   = 8'h08;
   localparam logic [7:0] ADDR_LCR   = 8'h0C;
   localparam logic [7:0] ADDR_LSR   = 8'h10;
   localparam logic [7:0] ADDR_IST   = 8'h14;
   localparam logic [7:0] ADDR_IMSK  = 8'h18;

   // Field positions
   localparam int FCR_FIFO_EN = 0;
   localparam int LCR_IR_MODE = 0;
   localparam int LCR_DIV_ACC = 7;
   localparam int LSR_DR      = 0;
   localparam int LSR_OE      = 1;
   localparam int LSR_TX_HOLD_EMPTY_FLAG    = 5;
   localparam int LSR_TEMT    = 6;
   localparam int IRQ_RX      = 0;
   localparam int IRQ_OVR     = 1;
   localparam int IRQ_TXE     = 2;
   localparam int IRQ_W       = 3;

   // Reset values
   localparam logic [7:0] DLL_RST = 8'h00;
   localparam logic [7:0] DLH_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [7:0] LCR_RST = 8'h00;

   // Timing in baud ticks (16 ticks per bit)
   localparam logic [3:0] PH_LAST   = 4'hF;
   localparam logic [3:0] PH_MID    = 4'h7;
   localparam logic [3:0] IR_PH_LO  = 4'h6;
   localparam logic [3:0] IR_PH_HI  = 4'h8;
   localparam logic [4:0] IR_STRETCH = 5'h10;

   typedef struct packed {
      logic tx_idle;
      logic tx_empty;
      logic overrun;
      logic rx_ready;
   } uddp_lsr_t;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uddp_ser_st_t;
endpackage

// ---- uddp_port.sv ----
// UART data and divisor port: Wishbone slave, baud divider, TX/RX FIFOs, shifters
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module uddp_port #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sin,
   input  wire logic        sir_in,
   output logic             sout,
   output logic             sir_out_n,
   output logic             irq
);
   localparam int PW = $clog2(FIFO_DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(FIFO_DEPTH);
   localparam int IRQ_W = uddp_pkg::IRQ_W;

   logic [7:0]      dll_r, dlh_r, fcr_r, lcr_r;
   logic            ack_r;
   logic [31:0]     dat_r;
   logic [31:0]     rd_mux;
   logic            ovr_r;
   logic [IRQ_W-1:0] ist_r, imsk_r;
   logic            tx_hold_empty_flag_q;
   logic [15:0]     div_cnt_r;
   logic [7:0]      tx_mem [FIFO_DEPTH];
   logic [PW-1:0]   tx_wp, tx_rp;
   logic [PW:0]     tx_cnt;
   logic [7:0]      rx_mem [FIFO_DEPTH];
   logic [PW-1:0]   rx_wp, rx_rp;
   logic [PW:0]     rx_cnt;
   uddp_pkg::uddp_ser_st_t tx_st, rx_st;
   logic [3:0]      tx_ph, rx_ph;
   logic [2:0]      tx_bc, rx_bc;
   logic [7:0]      tx_sh, rx_sh;
   logic            tx_bit;
   logic            rx_done;
   logic [1:0]      sin_s, sir_s;
   logic [4:0]      ir_cnt;
   uddp_pkg::uddp_lsr_t line_status_reg;

   // Bus decode: effects happen at the edge where the master sees ack
   wire req      = wb_cyc_i & wb_stb_i;
   wire acc      = req & ack_r;
   wire wr_acc   = acc & wb_we_i & wb_sel_i[0];
   wire rd_acc   = acc & ~wb_we_i;
   wire divisor_access_bit     = lcr_r[uddp_pkg::LCR_DIV_ACC];
   wire ir_mode  = lcr_r[uddp_pkg::LCR_IR_MODE];
   wire fifo_en  = fcr_r[uddp_pkg::FCR_FIFO_EN];
   wire port_hit = wb_adr_i == uddp_pkg::ADDR_DATA;
   wire tx_push  = wr_acc & port_hit & ~divisor_access_bit;
   wire dll_wr   = wr_acc & port_hit & divisor_access_bit;
   wire rx_pop   = rd_acc & port_hit & ~divisor_access_bit;
   wire fcr_wr   = wr_acc & (wb_adr_i == uddp_pkg::ADDR_FCR);
   // Switching FIFO mode flushes both queues, stale data would be misread
   wire fifo_clr = fcr_wr & (wb_dat_i[uddp_pkg::FCR_FIFO_EN] != fifo_en);
   wire [15:0] divisor = {dlh_r, dll_r};

   // one tick every divisor clocks, sixteen ticks per bit
   wire tick = (divisor != 16'h0000) & (div_cnt_r == divisor - 16'h0001);

   always_ff @(posedge sys_clk)
   begin
      if (rst || divisor == 16'h0000)
         div_cnt_r <= 16'h0000;
      else if (div_cnt_r >= divisor - 16'h0001)
         div_cnt_r <= 16'h0000;
      else
         div_cnt_r <= div_cnt_r + 16'h0001;
   end

   // Control registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         dll_r  <= uddp_pkg::DLL_RST;
         dlh_r  <= uddp_pkg::DLH_RST;
         fcr_r  <= uddp_pkg::FCR_RST;
         lcr_r  <= uddp_pkg::LCR_RST;
         imsk_r <= '0;
      end
      else if (wr_acc)
      begin
         if (dll_wr)
            dll_r <= wb_dat_i[7:0];
         if (wb_adr_i == uddp_pkg::ADDR_DLH)
            dlh_r <= wb_dat_i[7:0];
         if (fcr_wr)
            fcr_r <= wb_dat_i[7:0];
         if (wb_adr_i == uddp_pkg::ADDR_LCR)
            lcr_r <= wb_dat_i[7:0];
         if (wb_adr_i == uddp_pkg::ADDR_IMSK)
            imsk_r <= wb_dat_i[IRQ_W-1:0];
      end
   end

   // Transmit queue; depth one without FIFOs
   wire tx_full = fifo_en ? (tx_cnt == DEPTH_C) : (tx_cnt != '0);
   wire tx_load = (tx_st == uddp_pkg::ST_IDLE) & tick & (tx_cnt != '0);
   wire tx_ovw  = tx_push & ~fifo_en & (tx_cnt != '0) & ~tx_load;
   wire tx_wr   = tx_push & (~tx_full | (~fifo_en & tx_load));

   always_ff @(posedge sys_clk)
   begin
      if (tx_ovw)
         tx_mem[tx_rp] <= wb_dat_i[7:0];
      else if (tx_wr)
         tx_mem[tx_wp] <= wb_dat_i[7:0];
   end

   // empty flag follows the queue count
   always_ff @(posedge sys_clk)
   begin
      if (rst || fifo_clr)
      begin
         tx_wp  <= '0;
         tx_rp  <= '0;
         tx_cnt <= '0;
      end
      else
      begin
         if (tx_wr)
            tx_wp <= tx_wp + 1'b1;
         if (tx_load)
            tx_rp <= tx_rp + 1'b1;
         tx_cnt <= tx_cnt + {{PW{1'b0}}, tx_wr} - {{PW{1'b0}}, tx_load};
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tx_st  <= uddp_pkg::ST_IDLE;
         tx_ph  <= 4'h0;
         tx_bc  <= 3'h0;
         tx_sh  <= 8'h00;
         tx_bit <= 1'b1;
      end
      else if (tick)
      begin
         tx_ph <= tx_ph + 4'h1;
         case (tx_st)
            uddp_pkg::ST_IDLE:
            begin
               tx_ph <= 4'h0;
               if (tx_cnt != '0)
               begin
                  tx_sh  <= tx_mem[tx_rp];
                  tx_st  <= uddp_pkg::ST_START;
                  tx_bit <= 1'b0;
               end
            end
            uddp_pkg::ST_START:
               if (tx_ph == uddp_pkg::PH_LAST)
               begin
                  tx_st  <= uddp_pkg::ST_DATA;
                  tx_bc  <= 3'h0;
                  tx_bit <= tx_sh[0];
               end
            uddp_pkg::ST_DATA:
               if (tx_ph == uddp_pkg::PH_LAST)
               begin
                  if (tx_bc == 3'h7)
                  begin
                     tx_st  <= uddp_pkg::ST_STOP;
                     tx_bit <= 1'b1;
                  end
                  else
                  begin
                     tx_bc  <= tx_bc + 3'h1;
                     tx_sh  <= {1'b0, tx_sh[7:1]};
                     tx_bit <= tx_sh[1];
                  end
               end
            uddp_pkg::ST_STOP:
               if (tx_ph == uddp_pkg::PH_LAST)
                  tx_st <= uddp_pkg::ST_IDLE;
            default:
               tx_st <= uddp_pkg::ST_IDLE;
         endcase
      end
   end

   // infrared: 3/16-bit low pulse for each zero bit
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sout      <= 1'b1;
         sir_out_n <= 1'b1;
      end
      else
      begin
         sout      <= ir_mode | tx_bit;
         sir_out_n <= ~(ir_mode & ~tx_bit & (tx_st != uddp_pkg::ST_IDLE)
                        & (tx_ph >= uddp_pkg::IR_PH_LO) & (tx_ph <= uddp_pkg::IR_PH_HI));
      end
   end

   // Line inputs come from outside; two flops before use
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sin_s <= 2'b11;
         sir_s <= 2'b00;
      end
      else
      begin
         sin_s <= {sin_s[0], sin};
         sir_s <= {sir_s[0], sir_in};
      end
   end

   // Infrared pulse stretched to one bit time so the receiver sees a zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ir_cnt <= 5'h00;
      else if (sir_s[1])
         ir_cnt <= uddp_pkg::IR_STRETCH;
      else if (tick && ir_cnt != 5'h00)
         ir_cnt <= ir_cnt - 5'h01;
   end

   wire rx_line = ir_mode ? (ir_cnt == 5'h00) : sin_s[1];

   // Receive shifter, mid-bit sampling; a short start is dropped as noise
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rx_st   <= uddp_pkg::ST_IDLE;
         rx_ph   <= 4'h0;
         rx_bc   <= 3'h0;
         rx_sh   <= 8'h00;
         rx_done <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         if (tick)
         begin
            rx_ph <= rx_ph + 4'h1;
            case (rx_st)
               uddp_pkg::ST_IDLE:
               begin
                  rx_ph <= 4'h0;
                  if (!rx_line)
                     rx_st <= uddp_pkg::ST_START;
               end
               uddp_pkg::ST_START:
                  if (rx_ph == uddp_pkg::PH_MID && rx_line)
                     rx_st <= uddp_pkg::ST_IDLE;
                  else if (rx_ph == uddp_pkg::PH_LAST)
                  begin
                     rx_st <= uddp_pkg::ST_DATA;
                     rx_bc <= 3'h0;
                  end
               uddp_pkg::ST_DATA:
               begin
                  if (rx_ph == uddp_pkg::PH_MID)
                     rx_sh <= {rx_line, rx_sh[7:1]};
                  if (rx_ph == uddp_pkg::PH_LAST)
                  begin
                     if (rx_bc == 3'h7)
                        rx_st <= uddp_pkg::ST_STOP;
                     rx_bc <= rx_bc + 3'h1;
                  end
               end
               uddp_pkg::ST_STOP:
                  if (rx_ph == uddp_pkg::PH_MID)
                  begin
                     rx_done <= 1'b1;
                     rx_st   <= uddp_pkg::ST_IDLE;
                  end
               default:
                  rx_st <= uddp_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Receive queue; depth one without FIFOs
   wire rx_full = fifo_en ? (rx_cnt == DEPTH_C) : (rx_cnt != '0);
   wire rx_pope = rx_pop & (rx_cnt != '0);
   wire rx_wr   = rx_done & (~rx_full | rx_pope);
   wire rx_ovw  = rx_done & ~fifo_en & rx_full & ~rx_pope;
   // full FIFO drops the new byte
   wire rx_ovr  = rx_done & rx_full & ~rx_pope;

   always_ff @(posedge sys_clk)
   begin
      if (rx_ovw)
         rx_mem[rx_rp] <= rx_sh;
      else if (rx_wr)
         rx_mem[rx_wp] <= rx_sh;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst || fifo_clr)
      begin
         rx_wp  <= '0;
         rx_rp  <= '0;
         rx_cnt <= '0;
      end
      else
      begin
         if (rx_wr)
            rx_wp <= rx_wp + 1'b1;
         if (rx_pope)
            rx_rp <= rx_rp + 1'b1;
         rx_cnt <= rx_cnt + {{PW{1'b0}}, rx_wr} - {{PW{1'b0}}, rx_pope};
      end
   end

   // Overrun flag: cleared by a line status read, a new overrun wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ovr_r <= 1'b0;
      else if (rx_ovr)
         ovr_r <= 1'b1;
      else if (rd_acc && wb_adr_i == uddp_pkg::ADDR_LSR)
         ovr_r <= 1'b0;
   end

   // data-ready reflects a non-empty receive queue
   always_comb
   begin
      line_status_reg.rx_ready = rx_cnt != '0;
      line_status_reg.overrun  = ovr_r;
      line_status_reg.tx_empty = tx_cnt == '0;
      line_status_reg.tx_idle  = (tx_cnt == '0) & (tx_st == uddp_pkg::ST_IDLE);
   end

   // Sticky events, write one to clear; set wins over clear
   wire [IRQ_W-1:0] ev = {line_status_reg.tx_empty & ~tx_hold_empty_flag_q, rx_ovr, rx_wr | rx_ovw};
   wire [IRQ_W-1:0] ist_clr = (wr_acc && wb_adr_i == uddp_pkg::ADDR_IST) ?
                              wb_dat_i[IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ist_r  <= '0;
         tx_hold_empty_flag_q <= 1'b1;
         irq    <= 1'b0;
      end
      else
      begin
         ist_r  <= (ist_r & ~ist_clr) | ev;
         tx_hold_empty_flag_q <= line_status_reg.tx_empty;
         irq    <= |(((ist_r & ~ist_clr) | ev) & imsk_r);
      end
   end

   // Read data mux; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         uddp_pkg::ADDR_DATA: rd_mux[7:0] = divisor_access_bit ? dll_r : rx_mem[rx_rp];
         uddp_pkg::ADDR_DLH:  rd_mux[7:0] = dlh_r;
         uddp_pkg::ADDR_FCR:  rd_mux[7:0] = fcr_r;
         uddp_pkg::ADDR_LCR:  rd_mux[7:0] = lcr_r;
         uddp_pkg::ADDR_LSR:
         begin
            rd_mux[uddp_pkg::LSR_DR]   = line_status_reg.rx_ready;
            rd_mux[uddp_pkg::LSR_OE]   = line_status_reg.overrun;
            rd_mux[uddp_pkg::LSR_TX_HOLD_EMPTY_FLAG] = line_status_reg.tx_empty;
            rd_mux[uddp_pkg::LSR_TEMT] = line_status_reg.tx_idle;
         end
         uddp_pkg::ADDR_IST:  rd_mux[IRQ_W-1:0] = ist_r;
         uddp_pkg::ADDR_IMSK: rd_mux[IRQ_W-1:0] = imsk_r;
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (req && !ack_r)
            dat_r <= rd_mux;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [15:0] gap_r;
   logic        div_ok_r;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         gap_r    <= 16'h0000;
         div_ok_r <= 1'b0;
      end
      else
      begin
         gap_r    <= tick ? 16'h0000 : gap_r + 16'h0001;
         div_ok_r <= tick ? 1'b1 : (div_ok_r & $stable(divisor));
      end
   end

   baud_period_a: assert property (tick && div_ok_r && $stable(divisor) |-> gap_r == divisor - 16'h0001)
      else $error("baud tick spacing differs from divisor");
   baud_stop_a: assert property ((divisor == 16'h0000 && tx_st == uddp_pkg::ST_IDLE) |=> tx_st == uddp_pkg::ST_IDLE)
      else $error("transmitter started with zero divisor");
   tx_hold_empty_flag_clear_a: assert property (tx_push && !fifo_en && line_status_reg.tx_empty |=> !line_status_reg.tx_empty)
      else $error("transmit-empty not cleared by write");
   tx_replace_a: assert property (tx_ovw |=> tx_cnt == 1 && tx_mem[tx_rp] == $past(wb_dat_i[7:0]))
      else $error("pending transmit byte not replaced");
   tx_accept_a: assert property (tx_push && fifo_en && tx_cnt < DEPTH_C && !tx_load |=> tx_cnt == $past(tx_cnt) + 1'b1)
      else $error("transmit write not queued");
   tx_full_drop_a: assert property (tx_push && fifo_en && tx_cnt == DEPTH_C && !tx_load |=> tx_cnt == DEPTH_C)
      else $error("write into full transmit queue changed it");
   rx_overrun_a: assert property (rx_done && rx_full && !rx_pope |=> line_status_reg.overrun && rx_cnt == $past(rx_cnt))
      else $error("overrun not flagged or queue changed");
   rx_pop_a: assert property (rx_pop && rx_cnt != '0 && !rx_done |=> rx_cnt == $past(rx_cnt) - 1'b1)
      else $error("receive read did not pop");
   rx_ready_a: assert property (rx_done && !rx_full |=> line_status_reg.rx_ready)
      else $error("data-ready not set after reception");
   dll_access_a: assert property (dll_wr |=> dll_r == $past(wb_dat_i[7:0]) && tx_cnt == $past(tx_cnt))
      else $error("divisor low write misrouted");
endmodule // uddp_port

// ---- uddp_peer.sv ----
// Remote serial peer: frames bytes onto sin and decodes frames from sout
`timescale 1ns/1ps
module uddp_peer #(
   parameter int BIT_CYC = 16
) (
   input  wire logic sys_clk,
   input  wire logic sout,
   output logic      sin,
   output logic      sir_in
);
   logic [7:0] rx_q[$];
   logic [7:0] b;

   // Line idles high, infrared input idles with no pulse
   initial
   begin
      sin    = 1'b1;
      sir_in = 1'b0;
   end

   // start, eight data LSB first, stop
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge sys_clk);
         sin <= f[i];
         repeat (BIT_CYC - 1) @(posedge sys_clk);
      end
   endtask

   // centre sampling, so a wrong bit rate garbles the byte
   initial
   forever
   begin
      @(negedge sout);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge sys_clk);
         b[i] = sout;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      rx_q.push_back(b);
   end
endmodule // uddp_peer

// ---- uddp_port_tb.sv ----
// Self-checking bench for the data and divisor port
`timescale 1ns/1ps
module uddp_port_tb;
   localparam int DEPTH = 4;
   logic        sys_clk  = 1'b0;
   logic        rst      = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        sin;
   logic        sir_in;
   logic        sout;
   logic        sir_out_n;
   logic        irq;
   logic [31:0] rd;
   int          bad_count = 0;
   int          tests_run = 0;
   int          ir_low;
   int          ir_bad;

   always #50 sys_clk = ~sys_clk;

   uddp_port #(.FIFO_DEPTH(DEPTH)) uddp_port_inst (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sin(sin), .sir_in(sir_in),
      .sout(sout), .sir_out_n(sir_out_n), .irq(irq)
   );

   uddp_peer uddp_peer_inst (.sys_clk(sys_clk), .sout(sout), .sin(sin), .sir_in(sir_in));

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      chk8(nm, {7'h0, exp}, {7'h0, got});
   endtask

   // Classic cycle: hold until ack is sampled, then drop for one cycle
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, d};
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      if (n >= 50)
         chk1("ack", 1'b1, 1'b0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      xfer(1'b1, adr, d);
   endtask

   task automatic rdc(input string nm, input logic [7:0] adr, input logic [7:0] exp);
      xfer(1'b0, adr, 8'h00);
      chk8(nm, exp, rd[7:0]);
   endtask

   task automatic rdb(input string nm, input logic [7:0] adr, input int bi, input logic exp);
      xfer(1'b0, adr, 8'h00);
      chk1(nm, exp, rd[bi]);
   endtask

   // Divisor change waits the settle time before any traffic
   task automatic set_div(input logic [7:0] d);
      wr(uddp_pkg::ADDR_LCR, 8'h80);
      wr(uddp_pkg::ADDR_DATA, d);
      wr(uddp_pkg::ADDR_LCR, 8'h00);
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (uddp_peer_inst.rx_q.size() < n && k < 5000)
      begin
         @(posedge sys_clk);
         k++;
      end
   endtask

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      $display("BAD watchdog expected done seen hang");
      summarize();
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdc("lcr_rst", uddp_pkg::ADDR_LCR, uddp_pkg::LCR_RST);
      rdc("fcr_rst", uddp_pkg::ADDR_FCR, uddp_pkg::FCR_RST);
      rdc("dlh_rst", uddp_pkg::ADDR_DLH, uddp_pkg::DLH_RST);
      rdc("unmapped", 8'h1C, 8'h00);
      wr(uddp_pkg::ADDR_LCR, 8'h80);
      rdc("dll_rst", uddp_pkg::ADDR_DATA, uddp_pkg::DLL_RST);
      set_div(8'h01);
      wr(uddp_pkg::ADDR_LCR, 8'h80);
      rdc("dll_rw", uddp_pkg::ADDR_DATA, 8'h01);
      wr(uddp_pkg::ADDR_LCR, 8'h00);
      wr(uddp_pkg::ADDR_DATA, 8'h77);
      wait_rx(1);
      chk8("tx_byte", 8'h77, uddp_peer_inst.rx_q[0]);
      wr(uddp_pkg::ADDR_LCR, 8'h80);
      rdc("dll_kept", uddp_pkg::ADDR_DATA, 8'h01);
      set_div(8'h00);
      wr(uddp_pkg::ADDR_DATA, 8'h11);
      rdb("tx_hold_empty_flag_clr", uddp_pkg::ADDR_LSR, uddp_pkg::LSR_TX_HOLD_EMPTY_FLAG, 1'b0);
      wr(uddp_pkg::ADDR_DATA, 8'h22);
      repeat (100) @(posedge sys_clk);
      chk1("sout_still", 1'b1, sout);
      set_div(8'h01);
      wait_rx(3);
      repeat (200) @(posedge sys_clk);
      chk8("tx_replace", 8'h22, uddp_peer_inst.rx_q[1]);
      chk8("tx_count", 8'd2, 8'(uddp_peer_inst.rx_q.size()));
      wr(uddp_pkg::ADDR_FCR, 8'h01);
      set_div(8'h00);
      for (int i = 0; i < DEPTH + 2; i++)
         wr(uddp_pkg::ADDR_DATA, 8'hA0 + 8'(i));
      set_div(8'h01);
      wait_rx(DEPTH + 3);
      repeat (400) @(posedge sys_clk);
      chk8("txf_count", 8'(DEPTH + 2), 8'(uddp_peer_inst.rx_q.size()));
      for (int i = 0; i < DEPTH; i++)
         chk8("txf_byte", 8'hA0 + 8'(i), uddp_peer_inst.rx_q[2 + i]);
      for (int i = 0; i <= DEPTH; i++)
         uddp_peer_inst.send(8'hC0 + 8'(i));
      repeat (40) @(posedge sys_clk);
      rdb("rxf_ovr", uddp_pkg::ADDR_LSR, uddp_pkg::LSR_OE, 1'b1);
      chk1("rxf_ready", 1'b1, rd[uddp_pkg::LSR_DR]);
      for (int i = 0; i < DEPTH; i++)
         rdc("rxf_head", uddp_pkg::ADDR_DATA, 8'hC0 + 8'(i));
      rdb("rxf_empty", uddp_pkg::ADDR_LSR, uddp_pkg::LSR_DR, 1'b0);
      wr(uddp_pkg::ADDR_FCR, 8'h00);
      wr(uddp_pkg::ADDR_IMSK, 8'h00);
      wr(uddp_pkg::ADDR_IST, 8'h07);
      uddp_peer_inst.send(8'h3C);
      repeat (40) @(posedge sys_clk);
      rdb("ist_rx", uddp_pkg::ADDR_IST, uddp_pkg::IRQ_RX, 1'b1);
      chk1("irq_masked", 1'b0, irq);
      rdc("rx_byte", uddp_pkg::ADDR_DATA, 8'h3C);
      // Mask bits enable their source; status stays set until cleared
      wr(uddp_pkg::ADDR_IMSK, 8'h07);
      repeat (3) @(posedge sys_clk);
      chk1("irq_on", 1'b1, irq);
      wr(uddp_pkg::ADDR_IST, 8'h07);
      repeat (3) @(posedge sys_clk);
      chk1("irq_clear", 1'b0, irq);
      rdc("ist_clr", uddp_pkg::ADDR_IST, 8'h00);
      uddp_peer_inst.send(8'hA5);
      uddp_peer_inst.send(8'h5A);
      repeat (40) @(posedge sys_clk);
      rdb("rx_ovr", uddp_pkg::ADDR_LSR, uddp_pkg::LSR_OE, 1'b1);
      rdc("rx_last", uddp_pkg::ADDR_DATA, 8'h5A);
      // Infrared frame of zeros: start and eight data bits pulse three ticks each
      wr(uddp_pkg::ADDR_LCR, 8'h01);
      wr(uddp_pkg::ADDR_DATA, 8'h00);
      ir_low = 0;
      ir_bad = 0;
      repeat (400)
      begin
         @(negedge sys_clk);
         if (sir_out_n === 1'b0)
            ir_low++;
         if (sout !== 1'b1)
            ir_bad++;
      end
      chk8("ir_low_cycles", 8'd27, 8'(ir_low));
      chk8("ir_sout_high", 8'd0, 8'(ir_bad));
      summarize();
   end
endmodule // uddp_port_tb
